// >>> rie_params.svh
// offsets, field positions, reset values and row layout of the index entry builder
// assumes byte addresses on an 8-bit APB address, 32-bit data, one word per register
`ifndef RIE_PARAMS_SVH
`define RIE_PARAMS_SVH

// register byte offsets
`define RIE_OFF_CTRL       8'h00
`define RIE_OFF_STATUS     8'h04
`define RIE_OFF_FSIZE_LO   8'h08
`define RIE_OFF_FSIZE_HI   8'h0C
`define RIE_OFF_PREV_LO    8'h10
`define RIE_OFF_PREV_HI    8'h14

// control register fields
`define RIE_CTRL_START     0
`define RIE_CTRL_KIND      1
`define RIE_CTRL_FSIZE_EN  2
`define RIE_CTRL_HDR_EN    3
`define RIE_CTRL_ABS_EN    4
`define RIE_CTRL_FMT_LSB   5
`define RIE_CTRL_SPLIT     7
`define RIE_CTRL_CLEAR     8

// status register fields
`define RIE_STAT_BUSY      0
`define RIE_STAT_LOCK      1
`define RIE_STAT_PREV_V    2
`define RIE_STAT_CNT_LSB   16

// channel word fields
`define RIE_CSW_KIND       31
`define RIE_CSW_FSP        30
`define RIE_CSW_HDR        29

// reset values
`define RIE_RST_WORD       32'h0000_0000
`define RIE_RST_DWORD      64'h0000_0000_0000_0000

// stored entry row layout
`define RIE_ROW_W          200
`define RIE_ROW_CHAN       0
`define RIE_ROW_TYPE       16
`define RIE_ROW_OFF        24
`define RIE_ROW_ABS        88
`define RIE_ROW_REL        152

`endif

// >>> rie_pkg.sv
// types shared by the index entry builder files
// assumes nothing beyond a SystemVerilog compiler
package rie_pkg;

    // word emitter states, one-hot
    typedef enum logic [9:0] {
        RIE_S_IDLE  = 10'b00_0000_0001,
        RIE_S_CSW   = 10'b00_0000_0010,
        RIE_S_FSIZE = 10'b00_0000_0100,
        RIE_S_FETCH = 10'b00_0000_1000,
        RIE_S_PREP  = 10'b00_0001_0000,
        RIE_S_STAMP = 10'b00_0010_0000,
        RIE_S_HDR   = 10'b00_0100_0000,
        RIE_S_NODEW = 10'b00_1000_0000,
        RIE_S_OFFS  = 10'b01_0000_0000,
        RIE_S_SPARE = 10'b10_0000_0000
    } rie_state_t;

endpackage

// >>> rie_entry_mem.sv
// entry store: one write port, one read port with registered read data
// assumes a single clock and a writer that never writes past DEPTH entries
`timescale 1ns/1ps
module rie_entry_mem #(
    parameter int WIDTH = 200,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // write side
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    // read side
    input  wire logic             rd_en,
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data_r
);
    logic [WIDTH-1:0] mem [DEPTH];

    // array itself has no reset; only the read register does
    always_ff @(posedge pclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // read data held until the next read so the emitter may stall freely
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_data_r <= '0;
        end else if (rd_en) begin
            rd_data_r <= mem[rd_addr];
        end
    end
endmodule // rie_entry_mem

// >>> rie_stamp_sel.sv
// time stamp and data header former for one index entry
// assumes time inputs stand stable in the cycle that load is high
`timescale 1ns/1ps
`include "rie_params.svh"
module rie_stamp_sel #(
    parameter int HDR_BITS = 64
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // control
    input  wire logic        load,
    input  wire logic        abs_en,
    // time sources
    input  wire logic [47:0] rel_time,
    input  wire logic [63:0] abs_time,
    // formed fields
    output logic      [63:0] stamp_r,
    output logic      [63:0] header_r
);
    logic [63:0] hdr_mask;
    logic [63:0] stamp_nxt;
    logic [63:0] header_nxt;

    // unused high-order header bits forced to zero
    assign hdr_mask   = {64{1'b1}} >> (64 - HDR_BITS);
    assign stamp_nxt  = abs_en ? abs_time : {16'h0000, rel_time};
    assign header_nxt = abs_time & hdr_mask;

    // captured once per entry, held through any output stall
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stamp_r  <= `RIE_RST_DWORD;
            header_r <= `RIE_RST_DWORD;
        end else if (load) begin
            stamp_r  <= stamp_nxt;
            header_r <= header_nxt;
        end
    end
endmodule // rie_stamp_sel

// >>> rie_index_builder.sv
// index packet body builder: stores entries, emits the body as 32-bit words
// assumes an APB master on the register side and a writer with valid/ready downstream
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "rie_params.svh"
module rie_index_builder #(
    parameter int DEPTH    = 16,
    parameter int HDR_BITS = 64
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // entry input from the packet scanner
    input  wire logic        ent_valid,
    output logic             ent_ready,
    input  wire logic [15:0] ent_chan_id,
    input  wire logic [7:0]  ent_data_type,
    input  wire logic [63:0] ent_offset,
    input  wire logic [47:0] ent_rel_time,
    input  wire logic [63:0] ent_abs_time,
    // recorder time at packet start, used by the root tail stamp
    input  wire logic [47:0] cur_rel_time,
    input  wire logic [63:0] cur_abs_time,
    // body word stream
    output logic [31:0]      out_data,
    output logic             out_valid,
    input  wire logic        out_ready,
    output logic             out_last,
    // flags for the packet header builder
    output logic             pkt_abs_flag,
    output logic [1:0]       pkt_time_fmt
);
    localparam int AW = (DEPTH < 2) ? 1 : $clog2(DEPTH);

    // refuse sizes the counters and masks cannot serve
    if (DEPTH < 2 || DEPTH > 65535 || HDR_BITS < 1 || HDR_BITS > 64) begin : g_bad_param
        $error("rie_index_builder: DEPTH or HDR_BITS out of range");
    end

    rie_pkg::rie_state_t st_r, st_nxt;
    logic        hw_r, hw_nxt, tail_r, tail_nxt;
    logic [15:0] idx_r, idx_nxt, ent_cnt_r, pkt_cnt_r;
    logic        kind_r, fsen_r, split_r, hdr_en_r, abs_en_r, hdr_lock_r, prev_v_r;
    logic [1:0]  fmt_r;
    logic [63:0] fsize_r, prev_root_r;
    logic [47:0] cap_rel_r;
    logic [63:0] cap_abs_r;
    logic [31:0] out_data_r;
    logic        out_valid_r, out_last_r;
    logic [31:0] prdata_r;

    // apb decode
    logic        apb_setup, apb_wr, idle, start_go, clear_go;
    logic        sel_ctrl, sel_stat, sel_flo, sel_fhi, sel_plo, sel_phi, mapped;
    logic [31:0] rd_mux, ctrl_rd, stat_rd;
    assign apb_setup = psel & ~penable;
    assign apb_wr    = psel & penable & pwrite;
    assign sel_ctrl  = (paddr == `RIE_OFF_CTRL);
    assign sel_stat  = (paddr == `RIE_OFF_STATUS);
    assign sel_flo   = (paddr == `RIE_OFF_FSIZE_LO);
    assign sel_fhi   = (paddr == `RIE_OFF_FSIZE_HI);
    assign sel_plo   = (paddr == `RIE_OFF_PREV_LO);
    assign sel_phi   = (paddr == `RIE_OFF_PREV_HI);
    assign mapped    = sel_ctrl | sel_stat | sel_flo | sel_fhi | sel_plo | sel_phi;
    assign pready    = 1'b1;
    assign pslverr   = psel & penable & ~mapped;
    assign prdata    = prdata_r;
    // writes that would disturb a packet in flight are dropped while busy
    assign idle      = (st_r == rie_pkg::RIE_S_IDLE) & ~out_valid_r;
    assign start_go  = apb_wr & sel_ctrl & idle & pwdata[`RIE_CTRL_START];
    assign clear_go  = apb_wr & sel_ctrl & idle & pwdata[`RIE_CTRL_CLEAR];

    // register read views
    assign ctrl_rd = {24'h000000, split_r, fmt_r, abs_en_r, hdr_en_r, fsen_r, kind_r, 1'b0};
    assign stat_rd = {ent_cnt_r, 13'h0000, prev_v_r, hdr_lock_r, ~idle};
    assign rd_mux  = sel_ctrl ? ctrl_rd :
                     sel_stat ? stat_rd :
                     sel_flo  ? fsize_r[31:0] :
                     sel_fhi  ? fsize_r[63:32] :
                     sel_plo  ? prev_root_r[31:0] :
                     sel_phi  ? prev_root_r[63:32] : `RIE_RST_WORD;

    // read data latched in the setup phase, presented in the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= `RIE_RST_WORD;
        end else if (apb_setup) begin
            prdata_r <= pwrite ? `RIE_RST_WORD : rd_mux;
        end
    end

    // configuration; header choice locks at the first packet of a recording
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            kind_r     <= 1'b0;
            fsen_r     <= 1'b0;
            split_r    <= 1'b0;
            abs_en_r   <= 1'b0;
            fmt_r      <= 2'h0;
            hdr_en_r   <= 1'b0;
            hdr_lock_r <= 1'b0;
        end else if (apb_wr & sel_ctrl & idle) begin
            kind_r   <= pwdata[`RIE_CTRL_KIND];
            fsen_r   <= pwdata[`RIE_CTRL_FSIZE_EN];
            split_r  <= pwdata[`RIE_CTRL_SPLIT];
            abs_en_r <= pwdata[`RIE_CTRL_ABS_EN];
            fmt_r    <= pwdata[`RIE_CTRL_FMT_LSB +: 2];
            if (!hdr_lock_r || clear_go) begin
                hdr_en_r <= pwdata[`RIE_CTRL_HDR_EN];
            end
            hdr_lock_r <= start_go | (hdr_lock_r & ~clear_go);
        end
    end
    assign pkt_abs_flag = abs_en_r;
    assign pkt_time_fmt = fmt_r;

    // file size and previous root position
    logic  file_size_present_flag, root_done;
    assign file_size_present_flag       = fsen_r | split_r;
    assign root_done = (st_r == rie_pkg::RIE_S_OFFS) & tail_r & hw_r & (~out_valid_r | out_ready);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fsize_r     <= `RIE_RST_DWORD;
            prev_root_r <= `RIE_RST_DWORD;
            prev_v_r    <= 1'b0;
        end else begin
            if (apb_wr & idle & sel_flo) fsize_r[31:0] <= pwdata;
            if (apb_wr & idle & sel_fhi) fsize_r[63:32] <= pwdata;
            if (root_done) begin
                prev_root_r <= fsize_r;
                prev_v_r    <= 1'b1;
            end else if (clear_go) begin
                prev_v_r <= 1'b0;
            end
        end
    end

    // entry store; the scanner waits while a packet is being built
    logic                  ent_take;
    logic [`RIE_ROW_W-1:0] ent_row, row;
    assign ent_ready = idle & ~start_go & (ent_cnt_r < 16'(DEPTH));
    assign ent_take  = ent_valid & ent_ready;
    assign ent_row   = {ent_rel_time, ent_abs_time, ent_offset, ent_data_type, ent_chan_id};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ent_cnt_r <= 16'h0000;
            pkt_cnt_r <= 16'h0000;
            cap_rel_r <= 48'h0000_0000_0000;
            cap_abs_r <= `RIE_RST_DWORD;
        end else if (start_go) begin
            pkt_cnt_r <= ent_cnt_r;
            ent_cnt_r <= 16'h0000;
            cap_rel_r <= cur_rel_time;
            cap_abs_r <= cur_abs_time;
        end else if (ent_take) begin
            ent_cnt_r <= ent_cnt_r + 16'h0001;
        end
    end

    rie_entry_mem #(.WIDTH(`RIE_ROW_W), .DEPTH(DEPTH), .AW(AW)) u_mem (
        .pclk      (pclk),
        .presetn   (presetn),
        .wr_en     (ent_take),
        .wr_addr   (ent_cnt_r[AW-1:0]),
        .wr_data   (ent_row),
        .rd_en     (st_r == rie_pkg::RIE_S_FETCH),
        .rd_addr   (idx_r[AW-1:0]),
        .rd_data_r (row)
    );

    // stamp source: stored entry, or packet start time for the root tail
    logic [63:0] stamp, header, root_off, offs_val, node_word;
    rie_stamp_sel #(.HDR_BITS(HDR_BITS)) u_stamp (
        .pclk     (pclk),
        .presetn  (presetn),
        .load     (st_r == rie_pkg::RIE_S_PREP),
        .abs_en   (abs_en_r),
        .rel_time (tail_r ? cap_rel_r : row[`RIE_ROW_REL +: 48]),
        .abs_time (tail_r ? cap_abs_r : row[`RIE_ROW_ABS +: 64]),
        .stamp_r  (stamp),
        .header_r (header)
    );

    // word contents
    logic        can_load, emit_st, more;
    logic [31:0] csw_word, word_nxt;
    assign root_off  = prev_v_r ? prev_root_r : fsize_r;
    assign offs_val  = tail_r ? root_off : row[`RIE_ROW_OFF +: 64];
    assign node_word = {32'h0, 8'h00, row[`RIE_ROW_TYPE +: 8], row[`RIE_ROW_CHAN +: 16]};
    assign csw_word  = {kind_r, file_size_present_flag, hdr_en_r, 13'h0000, pkt_cnt_r};
    assign more      = (idx_r < pkt_cnt_r);
    assign can_load  = ~out_valid_r | out_ready;
    assign emit_st   = (st_r == rie_pkg::RIE_S_CSW)   | (st_r == rie_pkg::RIE_S_FSIZE) |
                       (st_r == rie_pkg::RIE_S_STAMP) | (st_r == rie_pkg::RIE_S_HDR) |
                       (st_r == rie_pkg::RIE_S_NODEW) | (st_r == rie_pkg::RIE_S_OFFS);

    function automatic logic [31:0] half(input logic [63:0] v, input logic hi);
        half = hi ? v[63:32] : v[31:0];
    endfunction

    // selected word for the current state and half
    always_comb begin
        case (st_r)
            rie_pkg::RIE_S_CSW:   word_nxt = csw_word;
            rie_pkg::RIE_S_FSIZE: word_nxt = half(fsize_r, hw_r);
            rie_pkg::RIE_S_STAMP: word_nxt = half(stamp, hw_r);
            rie_pkg::RIE_S_HDR:   word_nxt = half(header, hw_r);
            rie_pkg::RIE_S_NODEW: word_nxt = node_word[31:0];
            rie_pkg::RIE_S_OFFS:  word_nxt = half(offs_val, hw_r);
            default:              word_nxt = `RIE_RST_WORD;
        endcase
    end

    // sequencing of body fields
    always_comb begin
        st_nxt   = st_r;
        hw_nxt   = hw_r;
        idx_nxt  = idx_r;
        tail_nxt = tail_r;
        case (st_r)
            rie_pkg::RIE_S_IDLE: begin
                if (start_go) begin
                    st_nxt   = rie_pkg::RIE_S_CSW;
                    idx_nxt  = 16'h0000;
                    tail_nxt = 1'b0;
                    hw_nxt   = 1'b0;
                end
            end
            rie_pkg::RIE_S_CSW, rie_pkg::RIE_S_FSIZE, rie_pkg::RIE_S_OFFS: begin
                if (can_load && (st_r == rie_pkg::RIE_S_CSW)) begin
                    st_nxt = file_size_present_flag ? rie_pkg::RIE_S_FSIZE : rie_pkg::RIE_S_SPARE;
                end else if (can_load) begin
                    hw_nxt = ~hw_r;
                    if (hw_r) begin
                        st_nxt = tail_r ? rie_pkg::RIE_S_IDLE : rie_pkg::RIE_S_SPARE;
                    end
                end
            end
            rie_pkg::RIE_S_SPARE: begin
                // choose next entry, the root tail, or the end of the body
                if (more) begin
                    st_nxt = rie_pkg::RIE_S_FETCH;
                end else if (!kind_r) begin
                    st_nxt   = rie_pkg::RIE_S_PREP;
                    tail_nxt = 1'b1;
                end else begin
                    st_nxt = rie_pkg::RIE_S_IDLE;
                end
            end
            rie_pkg::RIE_S_FETCH: begin
                st_nxt  = rie_pkg::RIE_S_PREP;
                idx_nxt = idx_r + 16'h0001;
            end
            rie_pkg::RIE_S_PREP: st_nxt = rie_pkg::RIE_S_STAMP;
            rie_pkg::RIE_S_STAMP, rie_pkg::RIE_S_HDR: begin
                if (can_load) begin
                    hw_nxt = ~hw_r;
                    if (hw_r && hdr_en_r && (st_r == rie_pkg::RIE_S_STAMP)) begin
                        st_nxt = rie_pkg::RIE_S_HDR;
                    end else if (hw_r) begin
                        st_nxt = (kind_r && !tail_r) ? rie_pkg::RIE_S_NODEW : rie_pkg::RIE_S_OFFS;
                    end
                end
            end
            rie_pkg::RIE_S_NODEW: if (can_load) st_nxt = rie_pkg::RIE_S_OFFS;
            default: st_nxt = rie_pkg::RIE_S_IDLE;
        endcase
    end

    // a node body with no further entries ends at its last offset word, or at its channel or file size word when it holds no entries
    logic  ends_here;
    assign ends_here = (st_nxt == rie_pkg::RIE_S_IDLE) |
                       ((st_nxt == rie_pkg::RIE_S_SPARE) & ~more & kind_r);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r   <= rie_pkg::RIE_S_IDLE;
            hw_r   <= 1'b0;
            idx_r  <= 16'h0000;
            tail_r <= 1'b0;
        end else begin
            st_r   <= st_nxt;
            hw_r   <= hw_nxt;
            idx_r  <= idx_nxt;
            tail_r <= tail_nxt;
        end
    end

    // output word register, held while the writer stalls
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_data_r  <= `RIE_RST_WORD;
            out_valid_r <= 1'b0;
            out_last_r  <= 1'b0;
        end else if (emit_st && can_load) begin
            out_data_r  <= word_nxt;
            out_valid_r <= 1'b1;
            out_last_r  <= ends_here;
        end else if (out_ready) begin
            out_valid_r <= 1'b0;
            out_last_r  <= 1'b0;
        end
    end
    assign out_data  = out_data_r;
    assign out_valid = out_valid_r;
    assign out_last  = out_last_r;
endmodule // rie_index_builder

// >>> rie_builder_monitor.sv
// protocol checker for the index entry builder body stream and packet flags
// assumes it is bound to rie_index_builder and sees only that module's ports
`timescale 1ns/1ps
`include "rie_params.svh"
module rie_builder_monitor (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb side
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    // entry and body stream
    input wire logic        ent_ready,
    input wire logic [31:0] out_data,
    input wire logic        out_valid,
    input wire logic        out_ready,
    input wire logic        out_last,
    // packet flags
    input wire logic        pkt_abs_flag,
    input wire logic [1:0]  pkt_time_fmt
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // decode of a completed control write
    wire ctrl_wr = psel && penable && pwrite && (paddr == `RIE_OFF_CTRL);
    logic kind_r, fsp_r, hdr_r, in_pkt_r;
    wire  first_w = out_valid && !in_pkt_r;

    // remember the options of the last start; split forces the size field
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {kind_r, fsp_r, hdr_r, in_pkt_r} <= 4'h0;
        end else begin
            if (ctrl_wr && pwdata[0]) begin
                kind_r <= pwdata[1];
                fsp_r  <= pwdata[2] | pwdata[7];
                hdr_r  <= pwdata[3];
            end
            if (out_valid && out_ready) in_pkt_r <= !out_last;
        end
    end

    property p_hold;  out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_last); endproperty
    property p_abs;   !ctrl_wr |=> $stable(pkt_abs_flag); endproperty
    property p_fmt;   !ctrl_wr |=> $stable(pkt_time_fmt); endproperty
    property p_resv;  first_w |-> out_data[28:16] == 13'h0000; endproperty
    property p_kind;  first_w |-> out_data[31] == kind_r; endproperty
    property p_fsp;   first_w |-> out_data[30] == fsp_r; endproperty
    property p_hdr;   first_w |-> out_data[29] == hdr_r; endproperty
    property p_end;   out_valid && out_ready && out_last |=> !out_valid; endproperty
    property p_shut;  out_valid |-> !ent_ready; endproperty

    a_hold: assert property (p_hold) else $error("body word moved while stalled");
    a_abs: assert property (p_abs) else $error("abs flag moved without a write");
    a_fmt: assert property (p_fmt) else $error("time format moved without a write");
    a_resv: assert property (p_resv) else $error("channel word reserved bits set");
    a_kind: assert property (p_kind) else $error("kind flag wrong");
    a_fsp: assert property (p_fsp) else $error("file size flag wrong");
    a_hdr: assert property (p_hdr) else $error("header flag wrong");
    a_end: assert property (p_end) else $error("word after final word");
    a_shut: assert property (p_shut) else $error("entry taken while emitting");

    c_root: cover property (first_w && !out_data[31]);
    c_node: cover property (first_w && out_data[31]);
    c_stall: cover property (out_valid && !out_ready && out_last);
endmodule // rie_builder_monitor

bind rie_index_builder rie_builder_monitor rie_builder_monitor_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .ent_ready(ent_ready), .out_data(out_data),
    .out_valid(out_valid), .out_ready(out_ready), .out_last(out_last),
    .pkt_abs_flag(pkt_abs_flag), .pkt_time_fmt(pkt_time_fmt));

// >>> rie_sink_model.sv
// file writer model: takes body words with optional random stalls, keeps them in order
// assumes the builder holds each word under out_valid until out_ready
`timescale 1ns/1ps
module rie_sink_model (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // body stream
    input wire logic [31:0] out_data,
    input wire logic        out_valid,
    input wire logic        out_last,
    output logic            out_ready,
    // stall control
    input wire logic        stall_en
);
    logic [31:0] words[$];
    int          lasts;

    // a word counts only at an edge where valid and ready are both high
    always @(posedge pclk) begin
        if (presetn && out_valid && out_ready) begin
            words.push_back(out_data);
            if (out_last) lasts++;
        end
        out_ready <= stall_en ? 1'($urandom_range(1)) : 1'b1;
    end
endmodule // rie_sink_model

// >>> tb.sv
// self-checking bench: apb setup, entry feed, body words compared with a queue model
// assumes the sink model collects words and the monitor is bound to the builder
`timescale 1ns/1ps
`include "rie_params.svh"
module tb;
    // design connections
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, stall_en;
    logic [7:0]  paddr, ent_data_type;
    logic [31:0] pwdata, prdata, out_data;
    logic        ent_valid, ent_ready, out_valid, out_ready, out_last, pkt_abs_flag;
    logic [1:0]  pkt_time_fmt;
    logic [15:0] ent_chan_id;
    logic [63:0] ent_offset, ent_abs_time, cur_abs_time;
    logic [47:0] ent_rel_time, cur_rel_time;
    // model state
    int          mismatches, check_count;
    logic [31:0] exp_q[$];
    logic [63:0] prev_pos;
    logic        prev_ok;

    rie_index_builder #(.DEPTH(4), .HDR_BITS(64)) rie_index_builder_i (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ent_valid(ent_valid), .ent_ready(ent_ready), .ent_chan_id(ent_chan_id),
        .ent_data_type(ent_data_type), .ent_offset(ent_offset), .ent_rel_time(ent_rel_time),
        .ent_abs_time(ent_abs_time), .cur_rel_time(cur_rel_time), .cur_abs_time(cur_abs_time),
        .out_data(out_data), .out_valid(out_valid), .out_ready(out_ready), .out_last(out_last),
        .pkt_abs_flag(pkt_abs_flag), .pkt_time_fmt(pkt_time_fmt));
    rie_sink_model rie_sink_model_i (.pclk(pclk), .presetn(presetn), .out_data(out_data),
        .out_valid(out_valid), .out_last(out_last), .out_ready(out_ready), .stall_en(stall_en));

    // 100 MHz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask

    // model: 64-bit values go out low word first
    task automatic put64(input logic [63:0] v);
        exp_q.push_back(v[31:0]);
        exp_q.push_back(v[63:32]);
    endtask

    // feed n entries, start one body, compare every word with the model
    task automatic run_pkt(input logic kind, fsen, abs, split, input int n);
        logic [63:0] fs, ea, of;
        logic [47:0] er;
        logic [15:0] ch;
        logic [7:0]  ty;
        logic [1:0]  fmt;
        logic [31:0] q;
        logic        e;
        int          base, l0;
        fs = {$urandom, $urandom};
        fmt = 2'($urandom);
        exp_q = {};
        apb(1'b1, `RIE_OFF_FSIZE_LO, fs[31:0], q, e);
        apb(1'b1, `RIE_OFF_FSIZE_HI, fs[63:32], q, e);
        exp_q.push_back({kind, fsen | split, 1'b1, 13'h0000, 16'(n)});
        if (fsen | split) put64(fs);
        for (int i = 0; i < n; i++) begin
            ch = 16'($urandom); ty = 8'($urandom); of = {$urandom, $urandom};
            er = {16'($urandom), $urandom}; ea = {$urandom, $urandom};
            ent_valid <= 1'b1; ent_chan_id <= ch; ent_data_type <= ty; ent_offset <= of;
            ent_rel_time <= er; ent_abs_time <= ea;
            do @(posedge pclk); while (ent_ready !== 1'b1);
            put64(abs ? ea : {16'h0000, er});
            put64(ea);
            if (kind) exp_q.push_back({8'h00, ty, ch});
            put64(of);
        end
        er = {16'($urandom), $urandom}; ea = {$urandom, $urandom};
        ent_valid <= 1'b0; cur_rel_time <= er; cur_abs_time <= ea;
        @(posedge pclk);
        if (n == 4) check("entry ready when full", 64'h0, 64'(ent_ready));
        if (!kind) begin
            put64(abs ? ea : {16'h0000, er});
            put64(ea);
            put64(prev_ok ? prev_pos : fs);
            prev_pos = fs;
            prev_ok = 1'b1;
        end
        base = rie_sink_model_i.words.size();
        l0 = rie_sink_model_i.lasts;
        apb(1'b1, `RIE_OFF_CTRL, {23'h0, 1'b0, split, fmt, abs, 1'b1, fsen, kind, 1'b1}, q, e);
        check("abs flag", 64'(abs), 64'(pkt_abs_flag));
        check("time format", 64'(fmt), 64'(pkt_time_fmt));
        while (rie_sink_model_i.lasts == l0) @(posedge pclk);
        check("word count", 64'(exp_q.size()), 64'(rie_sink_model_i.words.size() - base));
        foreach (exp_q[i]) check($sformatf("word %0d", i), 64'(exp_q[i]), 64'(rie_sink_model_i.words[base + i]));
        apb(1'b0, `RIE_OFF_PREV_LO, 32'h0, q, e);
        check("previous root", 64'(prev_ok ? prev_pos[31:0] : 32'h0), 64'(q));
        $display("packet kind %0d entries %0d done", kind, n);
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // hang guard, well beyond the few hundred cycles the packets need
    initial begin
        #200000;
        mismatches++;
        report_and_stop();
    end

    initial begin
        logic [31:0] q;
        logic        e;
        void'($urandom(32'h24E8F081));
        {presetn, psel, penable, pwrite, ent_valid, stall_en} = 6'h00;
        paddr = 8'h00; pwdata = 32'h0; ent_chan_id = 16'h0; ent_data_type = 8'h00;
        {ent_offset, ent_abs_time, cur_abs_time} = '0;
        {ent_rel_time, cur_rel_time} = '0;
        prev_ok = 1'b0;
        prev_pos = 64'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // reset values, read-only place and an unmapped address
        apb(1'b0, `RIE_OFF_STATUS, 32'h0, q, e);
        check("status after reset", 64'h0, 64'(q));
        apb(1'b1, `RIE_OFF_PREV_LO, 32'hFFFF_FFFF, q, e);
        apb(1'b0, `RIE_OFF_PREV_LO, 32'h0, q, e);
        check("previous root read only", 64'h0, 64'(q));
        apb(1'b0, 8'h40, 32'h0, q, e);
        check("unmapped error", 64'h1, 64'(e));
        $display("register test done");
        run_pkt(1'b1, 1'b1, 1'b0, 1'b0, 2);
        stall_en <= 1'b1;
        run_pkt(1'b1, 1'b0, 1'b1, 1'b0, 4);
        run_pkt(1'b0, 1'b0, 1'b0, 1'b1, 1);
        run_pkt(1'b0, 1'b1, 1'b1, 1'b0, 0);
        report_and_stop();
    end
endmodule // tb
